// ---- rtl/powerup_seq_pkg.sv ----
package powerup_seq_pkg;

  localparam int CLK_MHZ           = 250;
  localparam int OSC_MHZ           = 48;
  localparam int OSC_SETTLE_NS     = 1000;
  localparam int OSC_SETTLE_CYC    = (OSC_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int STORE_DEPTH       = 16;
  localparam int STORE_AW          = 4;
  localparam int VOUT_W            = 8;
  localparam int ADC_W             = 10;
  localparam int ADDR_W            = 7;
  localparam int FREQ_W            = 11;
  localparam logic [FREQ_W-1:0] FREQ_MIN_KHZ = 11'h096;
  localparam logic [FREQ_W-1:0] FREQ_MAX_KHZ = 11'h5DC;
  localparam logic [FREQ_W-1:0] FREQ_REC_KHZ = 11'h1F4;
  localparam logic [FREQ_W-1:0] FREQ_DEF_KHZ = 11'h258;
  localparam logic [ADDR_W-1:0] BASE_ADDR_DEF = 7'h40;
  localparam logic [7:0] PRESET_BASE_REG   = 8'h77;
  localparam logic [STORE_AW-1:0] PRESET_IDX0 = 4'h7;

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_LOAD  = 3'b001,
    ST_ADDR  = 3'b011,
    ST_IDLE  = 3'b010,
    ST_RUN   = 3'b110
  } seq_state_t;

  typedef struct packed {
    logic bias_good;
    logic core_supply_rail_good;
    logic osc_running;
  } rails_t;

  typedef struct packed {
    logic                 valid;
    logic [STORE_AW-1:0]  index;
    logic [VOUT_W-1:0]    data;
  } cfg_write_t;

  typedef struct packed {
    logic              sw_mode;
    logic              sw_enable;
    logic              preset_mode;
    logic              disable_addr_offset;
    logic [FREQ_W-1:0] freq_khz;
    logic [VOUT_W-1:0] bus_vout;
  } host_cfg_t;

endpackage : powerup_seq_pkg

// ---- rtl/regulator_powerup_init_sequencer.sv ----
// Functional notes
// - Hold internal reset until bias rail, core rail and oscillator are all good.
// - After reset, copy the rewritable config store into working registers.
// - After load, accept host register writes regardless of enable pin.
// - Default: convert only with enable, input good, load done, address read.
// - Host software enable mode replaces the pin-based enable condition.
// - Three preset select pins choose one of eight output voltage settings.
// - Accept frequency settings within 150 to 1500 kHz; flag under 500 kHz.
// - Sample address resistor converter, add offset to base bus address.
// - Each preset combination selects one stored register holding the voltage code.
module regulator_powerup_init_sequencer
  import powerup_seq_pkg::*;
#(
  parameter int SETTLE_CYC = OSC_SETTLE_CYC
)(
  input  wire logic                 clock_in,
  input  wire logic                 reset_n_in,
  input  wire rails_t               rails_in,
  input  wire logic                 enable_pin_in,
  input  wire logic                 input_good_in,
  input  wire logic [2:0]           preset_select_pins_in,
  input  wire logic [VOUT_W-1:0]    store_rd_data_in,
  input  wire logic                 adc_valid_in,
  input  wire logic [ADC_W-1:0]     adc_code_in,
  input  wire cfg_write_t           host_wr_in,
  input  wire logic                 host_cfg_valid_in,
  input  wire host_cfg_t            host_cfg_in,
  output logic                      por_n_out,
  output logic                      load_done_out,
  output logic                      addr_read_out,
  output logic [STORE_AW-1:0]       store_rd_index_out,
  output logic                      convert_out,
  output logic [VOUT_W-1:0]         target_vout_out,
  output logic [ADDR_W-1:0]         bus_addr_out,
  output logic [FREQ_W-1:0]         freq_khz_out,
  output logic                      freq_low_out,
  output logic                      freq_reject_out
);

  seq_state_t                      state;
  seq_state_t                      next_state;
  logic [15:0]                     settle_cnt;
  logic [VOUT_W-1:0]               work_reg [STORE_DEPTH];
  logic [STORE_AW-1:0]             load_idx;
  logic [3:0]                      addr_offset;
  host_cfg_t                       cfg;

  // Oscillator must run continuously for SETTLE_CYC before it counts as stable.
  wire rails_ok      = rails_in.bias_good & rails_in.core_supply_rail_good;
  wire osc_stable    = rails_in.osc_running && (settle_cnt >= 16'(SETTLE_CYC));
  wire por_release   = rails_ok & osc_stable;
  wire load_last     = (load_idx == STORE_AW'(STORE_DEPTH - 1));
  wire host_wr_ok    = host_wr_in.valid & load_done_out;
  wire cfg_wr_ok     = host_cfg_valid_in & load_done_out;
  wire freq_in_range = (host_cfg_in.freq_khz >= FREQ_MIN_KHZ)
                     && (host_cfg_in.freq_khz <= FREQ_MAX_KHZ);
  wire enable_term   = cfg.sw_mode ? cfg.sw_enable : enable_pin_in;
  wire all_ok        = enable_term & input_good_in & load_done_out & addr_read_out;
  wire [STORE_AW-1:0] preset_idx = PRESET_IDX0 + STORE_AW'(preset_select_pins_in);
  wire [VOUT_W-1:0]  next_vout  = cfg.preset_mode ? work_reg[preset_idx] : cfg.bus_vout;
  // Offset is the top four converter bits: sixteen equal resistor bands.
  wire [3:0]         adc_offset = adc_code_in[ADC_W-1 -: 4];
  wire [ADDR_W-1:0]  next_addr  = cfg.disable_addr_offset ? BASE_ADDR_DEF
                                  : BASE_ADDR_DEF + ADDR_W'(addr_offset);

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RESET: if (por_release) next_state = ST_LOAD;
      ST_LOAD:  if (load_last) next_state = ST_ADDR;
      ST_ADDR:  if (adc_valid_in) next_state = ST_IDLE;
      ST_IDLE:  if (all_ok) next_state = ST_RUN;
      ST_RUN:   if (!all_ok) next_state = ST_IDLE;
      default:  next_state = ST_RESET;
    endcase
    if (!por_release)
      next_state = ST_RESET;
  end

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
      settle_cnt <= '0;
    else if (!rails_in.osc_running)
      settle_cnt <= '0;
    else if (!osc_stable)
      settle_cnt <= settle_cnt + 16'h0001;
  end

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
      state <= ST_RESET;
    else
      state <= next_state;
  end

  // Read data is taken one cycle after the index is presented.
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in || state == ST_RESET)
      load_idx <= '0;
    else if (state == ST_LOAD && !load_last)
      load_idx <= load_idx + 4'h1;
  end

  logic load_busy;
  logic [STORE_AW-1:0] load_wr_idx;
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      load_busy   <= 1'b0;
      load_wr_idx <= '0;
    end
    else
    begin
      load_busy   <= (state == ST_LOAD);
      load_wr_idx <= load_idx;
    end
  end

  genvar g;
  generate
    for (g = 0; g < STORE_DEPTH; g++)
    begin : g_work
      always_ff @(posedge clock_in)
      begin
        if (!reset_n_in)
          work_reg[g] <= '0;
        else if (load_busy && load_wr_idx == STORE_AW'(g))
          work_reg[g] <= store_rd_data_in;
        else if (host_wr_ok && host_wr_in.index == STORE_AW'(g))
          work_reg[g] <= host_wr_in.data;
      end
    end
  endgenerate

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in || state == ST_RESET)
    begin
      load_done_out <= 1'b0;
      addr_read_out <= 1'b0;
      addr_offset   <= '0;
    end
    else
    begin
      if (load_busy && state == ST_ADDR)
        load_done_out <= 1'b1;
      if (state == ST_ADDR && adc_valid_in)
      begin
        addr_read_out <= 1'b1;
        addr_offset   <= adc_offset;
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      cfg             <= '{default: '0, freq_khz: FREQ_DEF_KHZ};
      freq_reject_out <= 1'b0;
    end
    else if (cfg_wr_ok)
    begin
      cfg.sw_mode             <= host_cfg_in.sw_mode;
      cfg.sw_enable           <= host_cfg_in.sw_enable;
      cfg.preset_mode         <= host_cfg_in.preset_mode;
      cfg.disable_addr_offset <= host_cfg_in.disable_addr_offset;
      cfg.bus_vout            <= host_cfg_in.bus_vout;
      if (freq_in_range)
        cfg.freq_khz <= host_cfg_in.freq_khz;
      freq_reject_out <= !freq_in_range;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      por_n_out          <= 1'b0;
      store_rd_index_out <= '0;
      convert_out        <= 1'b0;
      target_vout_out    <= '0;
      bus_addr_out       <= BASE_ADDR_DEF;
      freq_khz_out       <= FREQ_DEF_KHZ;
      freq_low_out       <= 1'b0;
    end
    else
    begin
      por_n_out          <= por_release;
      // Entry zero is presented while still in reset state, so each entry pairs with its own slot.
      store_rd_index_out <= (state == ST_LOAD && !load_last) ? load_idx + 4'h1 : '0;
      convert_out        <= (next_state == ST_RUN);
      target_vout_out    <= next_vout;
      bus_addr_out       <= next_addr;
      freq_khz_out       <= cfg.freq_khz;
      freq_low_out       <= cfg.freq_khz < FREQ_REC_KHZ;
    end
  end

  property p_por_hold;
    @(posedge clock_in) disable iff (!reset_n_in)
      !rails_ok |=> !por_n_out;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset released with rails low");

  property p_load_first;
    @(posedge clock_in) disable iff (!reset_n_in)
      $rose(por_n_out) |-> !load_done_out;
  endproperty
  a_load_first: assert property (p_load_first) else $error("load done before load");

  property p_host_wr;
    @(posedge clock_in) disable iff (!reset_n_in)
      host_wr_in.valid && !load_done_out && !load_busy
        |=> work_reg[$past(host_wr_in.index)] == $past(work_reg[host_wr_in.index]);
  endproperty
  a_host_wr: assert property (p_host_wr) else $error("host write before load done");

  property p_conv_cond;
    @(posedge clock_in) disable iff (!reset_n_in)
      convert_out |-> load_done_out && addr_read_out;
  endproperty
  a_conv_cond: assert property (p_conv_cond) else $error("conversion without init");

  property p_sw_mode;
    @(posedge clock_in) disable iff (!reset_n_in)
      cfg.sw_mode && !cfg.sw_enable ##1 cfg.sw_mode |-> !convert_out;
  endproperty
  a_sw_mode: assert property (p_sw_mode) else $error("software disable ignored");

  property p_preset;
    @(posedge clock_in) disable iff (!reset_n_in)
      cfg.preset_mode |=> target_vout_out == $past(work_reg[preset_idx]);
  endproperty
  a_preset: assert property (p_preset) else $error("preset voltage mismatch");

  property p_freq;
    @(posedge clock_in) disable iff (!reset_n_in)
      ##1 freq_khz_out >= FREQ_MIN_KHZ && freq_khz_out <= FREQ_MAX_KHZ;
  endproperty
  a_freq: assert property (p_freq) else $error("frequency out of range");

  property p_addr;
    @(posedge clock_in) disable iff (!reset_n_in)
      addr_read_out && !cfg.disable_addr_offset
        |=> bus_addr_out == BASE_ADDR_DEF + ADDR_W'($past(addr_offset));
  endproperty
  a_addr: assert property (p_addr) else $error("bus address offset wrong");

  sequence s_cond_drop;
    convert_out ##0 !all_ok;
  endsequence
  property p_stop;
    @(posedge clock_in) disable iff (!reset_n_in)
      s_cond_drop |=> !convert_out;
  endproperty
  a_stop: assert property (p_stop) else $error("conversion did not stop");

endmodule : regulator_powerup_init_sequencer

// ---- testbench/config_store_model.sv ----
module config_store_model
  import powerup_seq_pkg::*;
(
  input  wire logic                clock_in,
  input  wire logic [STORE_AW-1:0] index_in,
  output logic      [VOUT_W-1:0]   data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Each entry carries its own index, so a load that pairs data with the wrong slot shows up.
  always_ff @(posedge clock_in)
  begin
    data_out <= {4'hA, index_in};
  end
endmodule : config_store_model

// ---- testbench/regulator_powerup_init_sequencer_bench.sv ----
module regulator_powerup_init_sequencer_bench
  import powerup_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [3:0]  ctl;
    logic [2:0]  pins;
    logic [10:0] freq;
    logic        conv;
    logic        rej;
    logic [7:0]  vout;
  } row_t;

  logic                clock_in;
  logic                reset_n_in;
  rails_t              rails_in;
  logic                enable_pin_in;
  logic                input_good_in;
  logic [2:0]          preset_select_pins_in;
  logic [VOUT_W-1:0]   store_rd_data_in;
  logic                adc_valid_in;
  logic [ADC_W-1:0]    adc_code_in;
  cfg_write_t          host_wr_in;
  logic                host_cfg_valid_in;
  host_cfg_t           host_cfg_in;
  logic                por_n_out;
  logic                load_done_out;
  logic                addr_read_out;
  logic [STORE_AW-1:0] store_rd_index_out;
  logic                convert_out;
  logic [VOUT_W-1:0]   target_vout_out;
  logic [ADDR_W-1:0]   bus_addr_out;
  logic [FREQ_W-1:0]   freq_khz_out;
  logic                freq_low_out;
  logic                freq_reject_out;
  int                  bad_count;
  int                  checks;

  // The ctl field holds software mode, software enable, enable pin and input good.
  row_t rows [8] = '{
    '{4'h3, 3'h0, 11'h258, 1'h1, 1'h0, 8'hA7},
    '{4'h1, 3'h1, 11'h096, 1'h0, 1'h0, 8'hA8},
    '{4'h2, 3'h2, 11'h5DC, 1'h0, 1'h0, 8'hA9},
    '{4'hD, 3'h3, 11'h095, 1'h1, 1'h1, 8'hAA},
    '{4'hB, 3'h4, 11'h5DD, 1'h0, 1'h1, 8'hAB},
    '{4'hF, 3'h5, 11'h258, 1'h1, 1'h0, 8'hAC},
    '{4'h6, 3'h6, 11'h258, 1'h0, 1'h0, 8'hAD},
    '{4'h3, 3'h7, 11'h258, 1'h1, 1'h0, 8'hAE}
  };

  regulator_powerup_init_sequencer #(.SETTLE_CYC(4)) uut (
    .clock_in, .reset_n_in, .rails_in, .enable_pin_in, .input_good_in,
    .preset_select_pins_in, .store_rd_data_in, .adc_valid_in, .adc_code_in,
    .host_wr_in, .host_cfg_valid_in, .host_cfg_in, .por_n_out, .load_done_out,
    .addr_read_out, .store_rd_index_out, .convert_out, .target_vout_out,
    .bus_addr_out, .freq_khz_out, .freq_low_out, .freq_reject_out
  );

  config_store_model store (
    .clock_in (clock_in),
    .index_in (store_rd_index_out),
    .data_out (store_rd_data_in)
  );

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask : cyc

  task automatic cfg(input host_cfg_t c);
    host_cfg_in = c;
    host_cfg_valid_in = 1'h1;
    cyc(1);
    host_cfg_valid_in = 1'h0;
  endtask : cfg

  task automatic wrap_up();
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    clock_in = 1'h0;
    forever #2 clock_in = ~clock_in;
  end

  initial
  begin
    reset_n_in = 1'h0;
    rails_in = 3'h0;
    enable_pin_in = 1'h0;
    input_good_in = 1'h0;
    preset_select_pins_in = 3'h0;
    adc_valid_in = 1'h1;
    adc_code_in = 10'h2C0;
    // A write this early must be dropped, so the store value wins in the first row.
    host_wr_in = '{1'h1, 4'h7, 8'hEE};
    host_cfg_valid_in = 1'h0;
    host_cfg_in = '0;
    cyc(2);
    reset_n_in = 1'h1;
    cyc(10);
    chk("por_n_out", 16'h0, 16'(por_n_out));
    chk("freq_khz_out", 16'(FREQ_DEF_KHZ), 16'(freq_khz_out));
    host_wr_in.valid = 1'h0;
    rails_in = 3'h7;
    for (int i = 0; i < 200 && por_n_out !== 1'b1; i++)
      cyc(1);
    // Entry zero must be presented first, or the first slot loads its neighbour.
    chk("store_rd_index_out", 16'h0, 16'(store_rd_index_out));
    cyc(1);
    chk("store_rd_index_out", 16'h1, 16'(store_rd_index_out));
    for (int i = 0; i < 200 && addr_read_out !== 1'b1; i++)
      cyc(1);
    if (addr_read_out !== 1'b1)
    begin
      bad_count++;
      wrap_up();
    end
    // The bus address takes the captured offset one edge after the address read.
    cyc(1);
    chk("por_n_out", 16'h1, 16'(por_n_out));
    chk("load_done_out", 16'h1, 16'(load_done_out));
    chk("bus_addr_out", 16'(BASE_ADDR_DEF) + 16'h000B, 16'(bus_addr_out));
    foreach (rows[i])
    begin
      preset_select_pins_in = rows[i].pins;
      enable_pin_in = rows[i].ctl[1];
      input_good_in = rows[i].ctl[0];
      cfg('{rows[i].ctl[3], rows[i].ctl[2], 1'h1, 1'h0, rows[i].freq, 8'h33});
      cyc(4);
      chk("convert_out", 16'(rows[i].conv), 16'(convert_out));
      chk("freq_reject_out", 16'(rows[i].rej), 16'(freq_reject_out));
      chk("target_vout_out", 16'(rows[i].vout), 16'(target_vout_out));
    end
    preset_select_pins_in = 3'h0;
    enable_pin_in = 1'h0;
    host_wr_in = '{1'h1, 4'h7, 8'h5C};
    cyc(1);
    host_wr_in.valid = 1'h0;
    cyc(3);
    chk("target_vout_out", 16'h5C, 16'(target_vout_out));
    chk("convert_out", 16'h0, 16'(convert_out));
    cfg('{1'h0, 1'h0, 1'h1, 1'h0, 11'h1F3, 8'h33});
    cyc(3);
    chk("freq_khz_out", 16'h1F3, 16'(freq_khz_out));
    chk("freq_low_out", 16'h1, 16'(freq_low_out));
    enable_pin_in = 1'h1;
    cyc(3);
    chk("convert_out", 16'h1, 16'(convert_out));
    // Losing the oscillator must pull the whole sequence back into reset.
    rails_in = 3'h6;
    cyc(3);
    chk("por_n_out", 16'h0, 16'(por_n_out));
    chk("convert_out", 16'h0, 16'(convert_out));
    // A second reset after the oscillator loss must return host settings and address to defaults.
    reset_n_in = 1'h0;
    cyc(2);
    reset_n_in = 1'h1;
    cyc(1);
    chk("freq_khz_out", 16'(FREQ_DEF_KHZ), 16'(freq_khz_out));
    chk("bus_addr_out", 16'(BASE_ADDR_DEF), 16'(bus_addr_out));
    chk("load_done_out", 16'h0, 16'(load_done_out));
    wrap_up();
  end
endmodule : regulator_powerup_init_sequencer_bench
